// File: shared/hsf_pkg.sv
package hsf_pkg;

  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_CTRL   = 3'h0;
  localparam logic [2:0] IDX_MASK   = 3'h1;
  localparam logic [2:0] IDX_LIVE   = 3'h2;
  localparam logic [2:0] IDX_FAULT  = 3'h3;
  localparam logic [2:0] IDX_SENSE  = 3'h4;
  localparam logic [2:0] IDX_SOURCE = 3'h5;
  localparam logic [2:0] IDX_AUX    = 3'h6;
  localparam logic [2:0] IDX_IRQ    = 3'h7;

  // field positions of the fault, mask and interrupt status registers
  localparam int FLT_SHORT = 5;
  localparam int FLT_BOARD = 4;
  localparam int FLT_PBAD  = 3;
  localparam int FLT_OC    = 2;
  localparam int FLT_UV    = 1;
  localparam int FLT_OV    = 0;
  localparam int FLT_W     = 6;

  // field positions of the control and live status registers
  localparam int test_mode_bit        = 5;
  localparam int power_bad_status_bit = 3;
  localparam int LIVE_GATE            = 7;
  localparam int LIVE_SHORT           = 5;
  localparam int LIVE_BOARD           = 4;
  localparam int LIVE_OC              = 2;
  localparam int LIVE_UV              = 1;
  localparam int LIVE_OV              = 0;

  // reset values and thresholds
  localparam logic [7:0] FAULT_RST   = 8'h00;
  localparam logic [7:0] ADC_RST     = 8'h00;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] SHORT_LIMIT = 8'h07;
  localparam logic [1:0] RESP_OKAY   = 2'h0;

  // comparator and gate pins sampled by the block
  typedef struct packed {
    logic board_inserted_n;
    logic output_good_feedback;
    logic undervoltage_input;
    logic overvoltage_input;
    logic gate_on;
    logic overcurrent;
  } hsf_pins_type;

  // one converter result set, offered with a valid pulse
  typedef struct packed {
    logic [7:0] sense;
    logic [7:0] source;
    logic [7:0] aux;
  } hsf_adc_type;

endpackage : hsf_pkg

// File: design/hsf_regs.sv
`timescale 1ns/100ps
module hsf_regs
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // pins and converter
  input  wire hsf_pkg::hsf_pins_type pins,
  input  wire logic                  adc_valid,
  input  wire hsf_pkg::hsf_adc_type  adc_data,
  output logic                       converter_halt,
  output logic                       irq,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  import hsf_pkg::*;

  logic [7:0]  ctrl_q;
  logic [7:0]  mask_q;
  logic [7:0]  fault_q;
  logic [7:0]  sense_q;
  logic [7:0]  source_q;
  logic [7:0]  aux_q;
  logic [FLT_W-1:0] irq_stat_q;
  logic        short_live_q;
  logic        seen_q;
  logic        board_prev_q;
  logic        uv_prev_q;
  logic        ov_prev_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [2:0]  aw_idx_q;
  logic [7:0]  w_data_q;
  logic        w_strb_q;
  logic        test_mode;
  logic        aw_fire;
  logic        w_fire;
  logic        ar_fire;
  logic        wr_go;
  logic        aw_have_n;
  logic        bvalid_n;
  logic        rvalid_n;
  logic [2:0]  ar_idx;
  logic        wr_fault;
  logic        wr_adc;
  logic        adc_take;
  logic [FLT_W-1:0] events;
  logic [7:0]  rd_mux;
  logic [7:0]  live;

  assign test_mode = ctrl_q[test_mode_bit];
  assign aw_fire   = s_axi_awvalid & s_axi_awready;
  assign w_fire    = s_axi_wvalid & s_axi_wready;
  assign ar_fire   = s_axi_arvalid & s_axi_arready;
  // write completes once both halves are held and no response waits
  assign wr_go     = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign aw_have_n = (aw_have_q | aw_fire) & ~wr_go;
  assign bvalid_n  = wr_go | (s_axi_bvalid & ~s_axi_bready);
  assign rvalid_n  = ar_fire | (s_axi_rvalid & ~s_axi_rready);
  // upper address bits are ignored, so every index aliases upward
  assign ar_idx    = s_axi_araddr[4:2];
  assign wr_fault  = wr_go & w_strb_q & (aw_idx_q == IDX_FAULT);
  assign wr_adc    = wr_go & w_strb_q & test_mode;
  assign adc_take  = adc_valid & ~test_mode;

  // fault events; edge events wait one cycle after reset for a history
  always_comb
  begin
    events            = '0;
    events[FLT_SHORT] = adc_take & ~pins.gate_on
                        & (adc_data.sense > SHORT_LIMIT);
    events[FLT_BOARD] = seen_q
                        & (pins.board_inserted_n != board_prev_q);
    events[FLT_PBAD]  = ~pins.output_good_feedback & pins.gate_on;
    events[FLT_OC]    = pins.overcurrent;
    events[FLT_UV]    = seen_q & uv_prev_q
                        & ~pins.undervoltage_input;
    events[FLT_OV]    = seen_q & ~ov_prev_q
                        & pins.overvoltage_input;
  end

  // live status view of the pins, plus the short flag judged on the last converter sample
  always_comb
  begin
    live                       = '0;
    live[LIVE_GATE]            = pins.gate_on;
    live[LIVE_SHORT]           = short_live_q;
    live[LIVE_BOARD]           = ~pins.board_inserted_n;
    live[power_bad_status_bit] = ~pins.output_good_feedback;
    live[LIVE_OC]              = pins.overcurrent;
    live[LIVE_UV]              = ~pins.undervoltage_input;
    live[LIVE_OV]              = pins.overvoltage_input;
  end

  // read data mux; narrow registers sit in the low byte
  always_comb
  begin
    case (ar_idx)
      IDX_CTRL:   rd_mux = ctrl_q;
      IDX_MASK:   rd_mux = mask_q;
      IDX_LIVE:   rd_mux = live;
      IDX_FAULT:  rd_mux = fault_q;
      IDX_SENSE:  rd_mux = sense_q;
      IDX_SOURCE: rd_mux = source_q;
      IDX_AUX:    rd_mux = aux_q;
      IDX_IRQ:    rd_mux = {2'b00, irq_stat_q};
      default:    rd_mux = 8'h00;
    endcase
  end

  // pin history for edge detection
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seen_q       <= 1'b0;
      board_prev_q <= 1'b0;
      uv_prev_q    <= 1'b0;
      ov_prev_q    <= 1'b0;
    end
    else
    begin
      seen_q       <= 1'b1;
      board_prev_q <= pins.board_inserted_n;
      uv_prev_q    <= pins.undervoltage_input;
      ov_prev_q    <= pins.overvoltage_input;
    end
  end

  // latched faults: write zero clears, one keeps, a new event wins
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_q <= FAULT_RST;
    else if (wr_fault)
      fault_q <= {2'b00, (fault_q[FLT_W-1:0] & w_data_q[FLT_W-1:0])
                         | events};
    else
      fault_q <= {2'b00, fault_q[FLT_W-1:0] | events};
  end

  // converter results; the host owns them while test mode is on
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_q      <= ADC_RST;
      source_q     <= ADC_RST;
      aux_q        <= ADC_RST;
      short_live_q <= 1'b0;
    end
    else if (adc_take)
    begin
      sense_q      <= adc_data.sense;
      source_q     <= adc_data.source;
      aux_q        <= adc_data.aux;
      short_live_q <= ~pins.gate_on & (adc_data.sense > SHORT_LIMIT);
    end
    else if (wr_adc)
    begin
      if (aw_idx_q == IDX_SENSE)
        sense_q <= w_data_q;
      if (aw_idx_q == IDX_SOURCE)
        source_q <= w_data_q;
      if (aw_idx_q == IDX_AUX)
        aux_q <= w_data_q;
    end
  end

  // control and mask registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end
    else if (wr_go && w_strb_q)
    begin
      if (aw_idx_q == IDX_CTRL)
        ctrl_q <= w_data_q;
      if (aw_idx_q == IDX_MASK)
        mask_q <= {2'b00, w_data_q[FLT_W-1:0]};
    end
  end

  // sticky interrupt status, cleared by reading it; events win
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_q <= '0;
    else if (ar_fire && ar_idx == IDX_IRQ)
      irq_stat_q <= events;
    else
      irq_stat_q <= irq_stat_q | events;
  end

  // outputs from flops; irq trails the status bit by one cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq            <= 1'b0;
      converter_halt <= 1'b0;
    end
    else
    begin
      irq            <= |(irq_stat_q & mask_q[FLT_W-1:0]);
      converter_halt <= test_mode;
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_idx_q      <= 3'h0;
      w_data_q      <= 8'h00;
      w_strb_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
    end
    else
    begin
      aw_have_q     <= aw_have_n;
      w_have_q      <= (w_have_q | w_fire) & ~wr_go;
      if (aw_fire)
        aw_idx_q <= s_axi_awaddr[4:2];
      if (w_fire)
      begin
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      s_axi_awready <= ~aw_have_n & ~bvalid_n;
      s_axi_wready  <= ~((w_have_q | w_fire) & ~wr_go) & ~bvalid_n;
      s_axi_bvalid  <= bvalid_n;
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
    end
    else
    begin
      s_axi_arready <= ~rvalid_n;
      s_axi_rvalid  <= rvalid_n;
      if (ar_fire)
        s_axi_rdata <= {24'h00_0000, rd_mux};
    end
  end

  // every index decodes, so every answer is okay
  assign s_axi_bresp = RESP_OKAY;
  assign s_axi_rresp = RESP_OKAY;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_fault_reserved: assert property (
    fault_q[7:6] == 2'b00)
    else $error("reserved fault bits set");

  chk_short_sets: assert property (
    events[FLT_SHORT] |=> fault_q[FLT_SHORT])
    else $error("short flag not set");

  chk_short_cause: assert property (
    $rose(fault_q[FLT_SHORT]) |->
      $past(adc_valid) && !$past(pins.gate_on)
      && $past(adc_data.sense) > SHORT_LIMIT)
    else $error("short flag without cause");

  chk_board_change: assert property (
    seen_q && $changed(pins.board_inserted_n) |=> fault_q[FLT_BOARD])
    else $error("board change missed");

  chk_pbad_cause: assert property (
    $rose(fault_q[FLT_PBAD]) |->
      !$past(pins.output_good_feedback) && $past(pins.gate_on))
    else $error("power bad set without cause");

  chk_pbad_sets: assert property (
    !pins.output_good_feedback && pins.gate_on |=> fault_q[FLT_PBAD])
    else $error("power bad not latched");

  chk_oc_sets: assert property (
    pins.overcurrent |=> fault_q[FLT_OC])
    else $error("overcurrent not latched");

  chk_uv_fall: assert property (
    seen_q && $fell(pins.undervoltage_input) |=> fault_q[FLT_UV])
    else $error("undervoltage not latched");

  chk_ov_rise: assert property (
    seen_q && $rose(pins.overvoltage_input) |=> fault_q[FLT_OV])
    else $error("overvoltage not latched");

  chk_flag_holds: assert property (
    fault_q[FLT_OV] && !wr_fault |=> fault_q[FLT_OV])
    else $error("fault flag dropped on its own");

  chk_halt_frozen: assert property (
    test_mode && !wr_go |=> $stable(sense_q) && $stable(aux_q))
    else $error("result changed in test mode");

  chk_host_locked: assert property (
    !test_mode && !adc_valid |=> $stable(source_q))
    else $error("result written outside test mode");

  chk_fault_read: assert property (
    ar_fire && ar_idx == IDX_FAULT |=> s_axi_rvalid
      && s_axi_rdata[7:0] == $past(fault_q))
    else $error("fault read mismatch");

  chk_live_pbad: assert property (
    ar_fire && ar_idx == IDX_LIVE |=>
      s_axi_rdata[3] == !$past(pins.output_good_feedback))
    else $error("live power bad wrong");

  cov_fault_clear: cover property (
    wr_fault && fault_q[FLT_UV] ##1 !fault_q[FLT_UV]);
  cov_test_write: cover property (wr_adc ##1 converter_halt);
  cov_irq_raise: cover property (irq ##[1:4] s_axi_rvalid);

endmodule : hsf_regs

// File: tb/hsf_host.sv
`timescale 1ns/100ps
// axi4-lite master standing in for the management host
module hsf_host (
  // clock
  input  wire logic        sys_clk,
  // write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  output logic             rready
);
  int hang = 0; // waits that ran out of cycles

  // idle bus at time zero
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
  end

  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit aw;
    bit w;
    bit b;
    aw = 1;
    w = 1;
    b = 0;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= 32'(d);
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (int n = 0; n < 40 && !b; n++)
    begin
      @(posedge sys_clk);
      if (aw && awready)
      begin
        aw = 0;
        awvalid <= 1'h0;
        awaddr  <= ~a; // released lines do not keep the old value
      end
      if (w && wready)
      begin
        w = 0;
        wvalid <= 1'h0;
        wdata  <= ~32'(d);
      end
      if (bvalid)
      begin
        b = 1;
        bready <= 1'h0;
      end
    end
    if (!b)
      hang++;
  endtask : wr

  // one read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bit r;
    r = 0;
    q = 'x;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (int n = 0; n < 40 && !r; n++)
    begin
      @(posedge sys_clk);
      if (arvalid && arready)
      begin
        arvalid <= 1'h0;
        araddr  <= ~a;
      end
      if (rvalid)
      begin
        r = 1;
        q = rdata;
        rready <= 1'h0;
      end
    end
    if (!r)
      hang++;
  endtask : rd
endmodule : hsf_host

// File: tb/hsf_regs_tb_top.sv
`timescale 1ns/100ps
// fault and converter result registers seen through pins and the host
module hsf_regs_tb_top;
  import hsf_pkg::*;
  typedef struct packed {
    hsf_pins_type p;
    logic [7:0]   f;
  } hsf_row_type;
  // board in, feedback good, no uv, no ov, gate on, no overcurrent
  localparam hsf_pins_type IDLE = 6'h1A;
  // one pin disturbance per row and the fault byte it should leave behind
  hsf_row_type rows [6] = '{{6'h3A, 8'h10}, {6'h0A, 8'h08}, {6'h08, 8'h00},
                           {6'h1B, 8'h04}, {6'h12, 8'h02}, {6'h1E, 8'h01}};

  logic         sys_clk;
  logic         rst_n;
  hsf_pins_type pins;
  logic         adc_valid;
  hsf_adc_type  adc_data;
  logic         converter_halt;
  logic         irq;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, q;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  int           n_mismatch = 0;
  int           samples_checked = 0;

  // 10 MHz clock
  initial
    sys_clk = 1'h0;
  always #50 sys_clk = ~sys_clk;

  hsf_regs i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .pins(pins), .adc_valid(adc_valid),
    .adc_data(adc_data), .converter_halt(converter_halt), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  hsf_host i_host (
    .sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    i_host.rd(a, q);
    chk(q, exp);
    chk(32'({bresp, rresp}), 32'h0000_0000);
  endtask : rdchk

  // one converter result pulse, then let it settle
  task automatic adc(input hsf_adc_type d);
    @(posedge sys_clk);
    adc_data  <= d;
    adc_valid <= 1'h1;
    @(posedge sys_clk);
    adc_valid <= 1'h0;
    repeat (2) @(posedge sys_clk);
  endtask : adc

  task automatic end_sim();
    n_mismatch += i_host.hang; // each exhausted wait counts as a mismatch
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // main sequence: reset, table of pin faults, then the awkward cases
  initial
  begin
    rst_n = 1'h0;
    pins = IDLE;
    adc_valid = 1'h0;
    adc_data = '0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'h1;
    for (int i = 3; i < 7; i++)
      rdchk(8'(4 * i), 32'h0000_0000);
    foreach (rows[i])
    begin
      pins <= rows[i].p;
      repeat (3) @(posedge sys_clk);
      pins <= IDLE;
      repeat (3) @(posedge sys_clk);
      rdchk(8'h0C, 32'(rows[i].f));
      i_host.wr(8'h0C, 8'hFF);
      rdchk(8'h0C, 32'(rows[i].f));
      i_host.wr(8'h0C, 8'h00);
      rdchk(8'hEC, 32'h0000_0000);
    end
    // gate off with feedback low: short judged on samples, no power-bad
    pins <= 6'h08;
    adc({8'h07, 8'h55, 8'hAA});
    rdchk(8'h0C, 32'h0000_0000);
    i_host.rd(8'h08, q);
    chk(32'(q[3]), 32'h0000_0001);
    adc({8'h08, 8'h66, 8'hBB});
    rdchk(8'h0C, 32'h0000_0020);
    rdchk(8'h10, 32'h0000_0008);
    rdchk(8'h14, 32'h0000_0066);
    rdchk(8'h18, 32'h0000_00BB);
    pins <= IDLE;
    i_host.wr(8'h0C, 8'h00);
    // test mode: samples dropped, host writes land
    i_host.wr(8'h00, 8'h20);
    repeat (2) @(posedge sys_clk);
    chk(32'(converter_halt), 32'h0000_0001);
    adc({8'h01, 8'h02, 8'h03});
    rdchk(8'h14, 32'h0000_0066);
    i_host.wr(8'h10, 8'h3C);
    rdchk(8'h10, 32'h0000_003C);
    i_host.wr(8'h00, 8'h00);
    i_host.wr(8'h10, 8'h11);
    rdchk(8'h10, 32'h0000_003C);
    // interrupt: event while masked, unmask, clear by reading status
    i_host.rd(8'h1C, q);
    pins <= 6'h1E;
    repeat (2) @(posedge sys_clk);
    pins <= IDLE;
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0000_0000);
    i_host.wr(8'h04, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0000_0001);
    rdchk(8'h1C, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0000_0000);
    // second reset in mid-run clears what the run left behind
    rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    rdchk(8'h0C, 32'h0000_0000);
    rdchk(8'h10, 32'h0000_0000);
    end_sim();
  end
endmodule : hsf_regs_tb_top
